// ==== rtl/lccr_pkg.sv ====
// lccr_pkg: constants and carrier types of the lane conditioning registers
package lccr_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_IDLE_RATE = 8'h2b;
  localparam logic [7:0] IDX_EQ = 8'h2c;
  localparam logic [7:0] IDX_SWING = 8'h2d;
  localparam logic [7:0] IDX_DEEMPH = 8'h2e;
  localparam logic [7:0] IDX_THRESH = 8'h2f;
  localparam logic [1:0] WORD_LSB = 2'h0;

  // ==========================================================
  // select codes produced by the address decoder
  localparam logic [2:0] SEL_IDLE_RATE = 3'h0;
  localparam logic [2:0] SEL_EQ = 3'h1;
  localparam logic [2:0] SEL_SWING = 3'h2;
  localparam logic [2:0] SEL_DEEMPH = 3'h3;
  localparam logic [2:0] SEL_THRESH = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ==========================================================
  // field positions
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT = 4;
  localparam int RATE_AUTO_BIT = 1;
  localparam int RATE_SEL_BIT = 0;
  localparam int EQ_EN_BIT = 5;
  localparam int DE_TYPE_BIT = 7;
  localparam logic [7:0] SWING_WR_MASK = 8'h3f;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_IDLE_RATE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h20;
  localparam logic [7:0] RST_SWING = 8'h03;
  localparam logic [7:0] RST_DEEMPH = 8'h03;
  localparam logic [7:0] RST_THRESH = 8'h00;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic auto_detect;
    logic mute;
    logic signal_detect_en;
    logic rate_auto;
    logic rate_high;
  } lccr_mode_t;

  typedef struct packed {
    logic enable;
    logic [1:0] gain_stage_select;
    logic [2:0] boost_level_select;
    logic [4:0] level_index;
    logic strap_match;
  } lccr_eq_t;

  typedef struct packed {
    logic [5:0] output_swing;
    logic [10:0] swing_mv;
    logic swing_valid;
    logic deemphasis_type;
    logic [6:0] deemphasis_level;
    logic [6:0] deemph_tenth_db;
    logic deemph_reserved;
    logic [7:0] deassert_mv;
    logic [7:0] assert_mv;
  } lccr_drv_t;

endpackage

// ==== rtl/lccr_mode_select.sv ====
// lccr_mode_select: resolves idle handling and rate band from their register
`timescale 1ns/1ps
module lccr_mode_select (
  // register value
  input wire logic [7:0] idle_rate,
  // resolved mode
  output lccr_pkg::lccr_mode_t mode
);

  // ==========================================================
  // idle and rate resolution
  always_comb begin
    mode.auto_detect = idle_rate[lccr_pkg::IDLE_AUTO_BIT];
    if (idle_rate[lccr_pkg::IDLE_AUTO_BIT]) begin
      // analog detector owns muting in automatic mode
      mode.mute = 1'b0;
      mode.signal_detect_en = 1'b1;
    end else begin
      mode.mute = idle_rate[lccr_pkg::IDLE_SEL_BIT];
      mode.signal_detect_en = 1'b0;
    end
    mode.rate_auto = idle_rate[lccr_pkg::RATE_AUTO_BIT];
    // forced band only counts when automatic detection is off
    mode.rate_high = !idle_rate[lccr_pkg::RATE_AUTO_BIT] &&
                     idle_rate[lccr_pkg::RATE_SEL_BIT];
  end

endmodule // lccr_mode_select

// ==== rtl/lccr_eq_decode.sv ====
// lccr_eq_decode: splits the equalizer code into enable, gain and boost
`timescale 1ns/1ps
module lccr_eq_decode (
  // register value
  input wire logic [7:0] eq_code,
  // decoded equalizer setting
  output lccr_pkg::lccr_eq_t eq
);

  // ==========================================================
  // field split and strap equivalence
  always_comb begin
    eq.enable = eq_code[lccr_pkg::EQ_EN_BIT];
    eq.gain_stage_select = eq_code[4:3];
    eq.boost_level_select = eq_code[2:0];
    // gain times eight plus boost is exactly the concatenation
    eq.level_index = eq_code[4:0];
    // the decode is linear; strap codes only add the strap_match flag
    unique case (eq_code[5:0])
      6'h20, 6'h2a, 6'h30, 6'h31, 6'h38,
      6'h34, 6'h35, 6'h3a, 6'h3c: eq.strap_match = 1'b1;
      default: eq.strap_match = 1'b0;
    endcase
  end

endmodule // lccr_eq_decode

// ==== rtl/lccr_top.sv ====
// lccr_top: per-channel lane conditioning registers behind an AHB-Lite slave
//
// Contract
// - Idle-automatic bit 5 at one lets the channel detect idle itself.
// - Forced idle bit 4 at zero keeps output on, detection off; one mutes.
// - Rate-automatic bit 1 selects auto rate, else bit 0 forces the band.
// - Equalizer bit 5 enables, bits 4:3 pick gain, bits 2:0 pick boost.
// - The equalizer register resets to bypass code 20 hex and reads so.
// - Strap-equivalent equalizer codes equalize as their pin settings.
// - Swing resets to 03 hex; 07, 0F, 1F, 3F give 800 to 1400 mV.
// - De-emphasis bit 7 is the type, bits 6:0 the level; reset 03 hex.
// - De-emphasis codes 01, 38, 88, 90, A0 map 0 to -12 dB; C0 reserved.
// - Threshold bits 3:2 give de-assert, bits 1:0 assert level.
`timescale 1ns/1ps
module lccr_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // decoded settings for the analog lane
  output lccr_pkg::lccr_mode_t mode_o,
  output lccr_pkg::lccr_eq_t eq_o,
  output lccr_pkg::lccr_drv_t drv_o
);

  // ==========================================================
  // address decode
  function automatic logic [2:0] reg_sel(input logic [31:0] addr);
    logic [2:0] sel;
    sel = lccr_pkg::SEL_NONE;
    if (addr == {22'h0, lccr_pkg::IDX_IDLE_RATE, lccr_pkg::WORD_LSB})
      sel = lccr_pkg::SEL_IDLE_RATE;
    if (addr == {22'h0, lccr_pkg::IDX_EQ, lccr_pkg::WORD_LSB})
      sel = lccr_pkg::SEL_EQ;
    if (addr == {22'h0, lccr_pkg::IDX_SWING, lccr_pkg::WORD_LSB})
      sel = lccr_pkg::SEL_SWING;
    if (addr == {22'h0, lccr_pkg::IDX_DEEMPH, lccr_pkg::WORD_LSB})
      sel = lccr_pkg::SEL_DEEMPH;
    if (addr == {22'h0, lccr_pkg::IDX_THRESH, lccr_pkg::WORD_LSB})
      sel = lccr_pkg::SEL_THRESH;
    return sel;
  endfunction

  logic [7:0] idle_rate_reg;
  logic [7:0] eq_reg;
  logic [7:0] swing_reg;
  logic [7:0] deemph_reg;
  logic [7:0] thresh_reg;
  logic wr_pend_reg;
  logic [2:0] wr_sel_reg;
  logic addr_phase;
  logic [2:0] ap_sel;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  assign addr_phase = hsel && hready && htrans[1];
  assign ap_sel = reg_sel(haddr);
  // swing upper bits are not storable, so they always read as zero
  assign wr_byte = (wr_sel_reg == lccr_pkg::SEL_SWING) ?
                   (hwdata[7:0] & lccr_pkg::SWING_WR_MASK) : hwdata[7:0];

  // ==========================================================
  // bus phase tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= lccr_pkg::SEL_NONE;
    end else if (hready) begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_sel_reg <= ap_sel;
    end
  end

  // zero wait states and always OKAY
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // register storage, written in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_rate_reg <= lccr_pkg::RST_IDLE_RATE;
      eq_reg <= lccr_pkg::RST_EQ;
      swing_reg <= lccr_pkg::RST_SWING;
      deemph_reg <= lccr_pkg::RST_DEEMPH;
      thresh_reg <= lccr_pkg::RST_THRESH;
    end else if (wr_pend_reg) begin
      unique case (wr_sel_reg)
        lccr_pkg::SEL_IDLE_RATE: idle_rate_reg <= wr_byte;
        lccr_pkg::SEL_EQ: eq_reg <= wr_byte;
        lccr_pkg::SEL_SWING: swing_reg <= wr_byte;
        lccr_pkg::SEL_DEEMPH: deemph_reg <= wr_byte;
        lccr_pkg::SEL_THRESH: thresh_reg <= wr_byte;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read path; a read right behind a write sees the new byte
  always_comb begin
    unique case (ap_sel)
      lccr_pkg::SEL_IDLE_RATE: rd_byte = idle_rate_reg;
      lccr_pkg::SEL_EQ: rd_byte = eq_reg;
      lccr_pkg::SEL_SWING: rd_byte = swing_reg;
      lccr_pkg::SEL_DEEMPH: rd_byte = deemph_reg;
      lccr_pkg::SEL_THRESH: rd_byte = thresh_reg;
      default: rd_byte = 8'h00;
    endcase
    if (wr_pend_reg && wr_sel_reg == ap_sel &&
        ap_sel != lccr_pkg::SEL_NONE) begin
      rd_byte = wr_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // decoders
  lccr_pkg::lccr_mode_t mode_next;
  lccr_pkg::lccr_eq_t eq_next;
  lccr_pkg::lccr_drv_t drv_next;

  lccr_mode_select u_mode (
    .idle_rate(idle_rate_reg),
    .mode(mode_next)
  );

  lccr_eq_decode u_eq (
    .eq_code(eq_reg),
    .eq(eq_next)
  );

  always_comb begin
    drv_next.output_swing = swing_reg[5:0];
    unique case (swing_reg[5:0])
      6'h03: drv_next.swing_mv = 11'h258;
      6'h07: drv_next.swing_mv = 11'h320;
      6'h0f: drv_next.swing_mv = 11'h3e8;
      6'h1f: drv_next.swing_mv = 11'h4b0;
      6'h3f: drv_next.swing_mv = 11'h578;
      default: drv_next.swing_mv = 11'h000;
    endcase
    drv_next.swing_valid = drv_next.swing_mv != 11'h000;
    drv_next.deemphasis_type = deemph_reg[lccr_pkg::DE_TYPE_BIT];
    drv_next.deemphasis_level = deemph_reg[6:0];
    // attenuation in tenths of a dB; unlisted codes report zero
    unique case (deemph_reg)
      8'h38: drv_next.deemph_tenth_db = 7'h23;
      8'h88: drv_next.deemph_tenth_db = 7'h3c;
      8'h90: drv_next.deemph_tenth_db = 7'h5a;
      8'ha0: drv_next.deemph_tenth_db = 7'h78;
      default: drv_next.deemph_tenth_db = 7'h00;
    endcase
    drv_next.deemph_reserved = deemph_reg == 8'hc0;
    unique case (thresh_reg[3:2])
      2'h0: drv_next.deassert_mv = 8'h6e;
      2'h1: drv_next.deassert_mv = 8'h96;
      2'h2: drv_next.deassert_mv = 8'haa;
      default: drv_next.deassert_mv = 8'hbe;
    endcase
    unique case (thresh_reg[1:0])
      2'h0: drv_next.assert_mv = 8'h46;
      2'h1: drv_next.assert_mv = 8'h6e;
      2'h2: drv_next.assert_mv = 8'h82;
      default: drv_next.assert_mv = 8'h96;
    endcase
  end

  // ==========================================================
  // output flops: one cycle behind the registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_o <= '0;
      eq_o <= '0;
      drv_o <= '0;
    end else begin
      mode_o <= mode_next;
      eq_o <= eq_next;
      drv_o <= drv_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic eq_written_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_written_reg <= 1'b0;
    end else if (wr_pend_reg && wr_sel_reg == lccr_pkg::SEL_EQ) begin
      eq_written_reg <= 1'b1;
    end
  end

  idle_auto_a: assert property (
    ##1 mode_o.auto_detect == $past(idle_rate_reg[5])
      && (!mode_o.auto_detect || mode_o.signal_detect_en))
    else $error("idle auto mode not followed");

  forced_idle_a: assert property (
    (!idle_rate_reg[5] && !idle_rate_reg[4])
      |=> !mode_o.mute && !mode_o.signal_detect_en)
    else $error("forced idle output state wrong");

  forced_mute_a: assert property (
    (!idle_rate_reg[5] && idle_rate_reg[4]) [*2] |-> mode_o.mute)
    else $error("forced mute not applied");

  rate_band_a: assert property (
    ##1 mode_o.rate_high == ($past(idle_rate_reg[1:0]) == 2'h1)
      && mode_o.rate_auto == $past(idle_rate_reg[1]))
    else $error("rate band selection wrong");

  eq_fields_a: assert property (
    $changed(eq_reg) |=> eq_o.level_index ==
      {$past(eq_reg[4:3]), $past(eq_reg[2:0])}
      && eq_o.enable == $past(eq_reg[5]))
    else $error("equalizer fields misdecoded");

  // the release edge still loads the cleared outputs, so start one later
  eq_reset_a: assert property (
    rst_n && !eq_written_reg |-> eq_reg == 8'h20 ##1 eq_o.strap_match)
    else $error("equalizer left bypass without a write");

  eq_strap_a: assert property (
    eq_reg[5:0] == 6'h3c |=> eq_o.strap_match && eq_o.enable
      && eq_o.gain_stage_select == 2'h3)
    else $error("strap code not recognised");

  swing_map_a: assert property (
    swing_reg[7:6] == 2'h0
      and (swing_reg == 8'h3f |=> drv_o.swing_mv == 11'h578))
    else $error("swing register or decode wrong");

  deemph_map_a: assert property (
    deemph_reg == 8'h88 |=> drv_o.deemph_tenth_db == 7'h3c
      && drv_o.deemphasis_type && !drv_o.deemph_reserved)
    else $error("deemphasis decode wrong");

  thresh_map_a: assert property (
    thresh_reg[3:0] == 4'h6 |=> drv_o.deassert_mv == 8'h96
      && drv_o.assert_mv == 8'h82)
    else $error("idle threshold decode wrong");

  read_back_a: assert property (
    (addr_phase && !hwrite && ap_sel == lccr_pkg::SEL_DEEMPH
      && !wr_pend_reg) |=> hrdata[7:0] == $past(deemph_reg))
    else $error("read data does not match register");

  forced_mute_c: cover property (!idle_rate_reg[5] ##1 mode_o.mute);
  rate_high_c: cover property (mode_o.rate_high);
  deemph_res_c: cover property (drv_o.deemph_reserved);
  eq_write_c: cover property ($rose(eq_written_reg) ##1 !eq_o.strap_match);

endmodule // lccr_top

// ==== verification/lccr_top_tb_top.sv ====
// lccr_top_tb_top: self-checking bench for the lane conditioning registers
`timescale 1ns/1ps
module lccr_top_tb_top;
  // ==========================================================
  // bench signals
  logic ref_clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  lccr_pkg::lccr_mode_t mode_o;
  lccr_pkg::lccr_eq_t eq_o;
  lccr_pkg::lccr_drv_t drv_o;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] mcode [6] = '{8'h20, 8'h10, 8'h00, 8'h32, 8'h01, 8'h03};
  logic [4:0] mexp [6] = '{5'h14, 5'h08, 5'h00, 5'h16, 5'h01, 5'h02};
  logic [7:0] ecode [9] = '{8'h2a, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35,
                            8'h3a, 8'h3c, 8'h2b};
  logic [7:0] dcode [6] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'ha0, 8'hc0};
  int dtenth [6] = '{0, 35, 60, 90, 120, 0};
  int tdeas [4] = '{110, 150, 170, 190};

  // one slave: its ready is the bus ready
  assign hready = hreadyout;

  lccr_top i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .mode_o(mode_o),
    .eq_o(eq_o),
    .drv_o(drv_o)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang ends the run here; far above the roughly 150 cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, lccr_pkg::WORD_LSB};
  endfunction

  // single ahb-lite transfer; no wait count assumed, the timeout bounds it
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
    chk(32'h0, {31'h0, hresp});
  endtask

  // write, then let the decoded outputs follow one edge later
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, adr(idx), d, rd);
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, adr(idx), 8'h00, rd);
    chk({24'h0, e}, rd);
  endtask

  // ==========================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(32'h1, {31'h0, eq_o.strap_match});
    chk(32'd600, {21'h0, drv_o.swing_mv});
    chk(32'h3, {25'h0, drv_o.deemphasis_level});
    chk(32'd110, {24'h0, drv_o.deassert_mv});
    chk(32'd70, {24'h0, drv_o.assert_mv});
    rdc(lccr_pkg::IDX_IDLE_RATE, 8'h00);
    rdc(lccr_pkg::IDX_EQ, 8'h20);
    rdc(lccr_pkg::IDX_SWING, 8'h03);
    rdc(lccr_pkg::IDX_DEEMPH, 8'h03);
    rdc(lccr_pkg::IDX_THRESH, 8'h00);
    $display("reset values test done");

    for (int i = 0; i < 6; i++) begin
      wr(lccr_pkg::IDX_IDLE_RATE, mcode[i]);
      chk({27'h0, mexp[i]}, {27'h0, mode_o});
      rdc(lccr_pkg::IDX_IDLE_RATE, mcode[i]);
    end
    $display("idle and rate mode test done");

    // last code is not a strap setting
    for (int i = 0; i < 9; i++) begin
      wr(lccr_pkg::IDX_EQ, ecode[i]);
      chk({20'h0, ecode[i][5:0], ecode[i][4:0], i < 8},
          {20'h0, eq_o});
    end
    rdc(lccr_pkg::IDX_EQ, 8'h2b);
    $display("equalizer test done");

    for (int i = 0; i < 5; i++) begin
      wr(lccr_pkg::IDX_SWING, 8'((4 << i) - 1));
      chk(32'(600 + 200 * i), {21'h0, drv_o.swing_mv});
      chk(32'h1, {31'h0, drv_o.swing_valid});
      chk(32'((4 << i) - 1), {26'h0, drv_o.output_swing});
    end
    wr(lccr_pkg::IDX_SWING, 8'hc5);
    chk(32'h5, {26'h0, drv_o.output_swing});
    rdc(lccr_pkg::IDX_SWING, 8'h05);
    chk(32'h0, {31'h0, drv_o.swing_valid});
    $display("output swing test done");

    for (int i = 0; i < 6; i++) begin
      wr(lccr_pkg::IDX_DEEMPH, dcode[i]);
      chk({24'h0, dcode[i]},
          {24'h0, drv_o.deemphasis_type, drv_o.deemphasis_level});
      chk(32'(i == 5), {31'h0, drv_o.deemph_reserved});
      if (i < 5) begin
        chk(32'(dtenth[i]), {25'h0, drv_o.deemph_tenth_db});
      end
    end
    $display("de-emphasis test done");

    // de-assert and assert codes run in opposite directions
    for (int i = 0; i < 4; i++) begin
      wr(lccr_pkg::IDX_THRESH, 8'((i << 2) | (3 - i)));
      chk(32'(tdeas[i]), {24'h0, drv_o.deassert_mv});
      chk(32'(tdeas[3 - i] - 40), {24'h0, drv_o.assert_mv});
    end
    $display("idle threshold test done");

    // write then read with an idle cycle between, unmapped and aliased addresses
    xfer(1'b1, adr(lccr_pkg::IDX_THRESH), 8'h09, rd);
    xfer(1'b0, adr(lccr_pkg::IDX_THRESH), 8'h00, rd);
    chk(32'h9, rd);
    xfer(1'b1, 32'h1000_00bc, 8'hff, rd);
    xfer(1'b1, 32'h0000_00c0, 8'h5a, rd);
    xfer(1'b0, 32'h0000_00c0, 8'h00, rd);
    chk(32'h0, rd);
    rdc(lccr_pkg::IDX_THRESH, 8'h09);
    $display("bus access test done");
    finish_test();
  end
endmodule // lccr_top_tb_top
